// ==== core/phy_mode_defines.svh ====
// Offsets, field positions, reset values and timing counts of the mode block
`ifndef PHY_MODE_DEFINES_SVH
`define PHY_MODE_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_CONTROL      5'h00
`define IDX_STATUS       5'h01
`define IDX_ID_HIGH      5'h02
`define IDX_ID_LOW       5'h03
`define IDX_AN_ADVERT    5'h04
`define IDX_AN_PARTNER   5'h05
`define IDX_AN_EXPANSION 5'h06
`define IDX_AN_NEXT_PAGE 5'h07
`define IDX_PARTNER_NP   5'h08
`define IDX_RX_ERR_COUNT 5'h15
`define IDX_MODE_STATUS  5'h1e
`define IDX_IRQ_CTRL     5'h1b
`define IDX_VENDOR_CTRL  5'h1f

// Basic control bit positions
`define CTL_RESET      15
`define CTL_LOOPBACK   14
`define CTL_SPEED      13
`define CTL_AN_ENABLE  12
`define CTL_POWER_DOWN 11
`define CTL_ISOLATE    10
`define CTL_AN_RESTART 9
`define CTL_DUPLEX     8
`define CTL_COL_TEST   7
`define CTL_TX_DISABLE 0
`define CTL_RW_MASK    16'h7d81

// Vendor control bit positions and reset value
`define VND_MDIX_DISABLE 13
`define VND_PS_DISABLE   10
`define VND_RW_MASK      16'h2400
`define VND_RESET        16'h0000

// Basic status: ability flags 15:11 and link bit
`define STS_ABILITY_LSB 11
`define STS_ABILITY     5'h0f
`define STS_LINK        2

// Far-end-fault pattern: ones before the single zero
`define FEF_ONES 84

// Software reset hold time
`define CLK_PERIOD_NS   10
`define SW_RESET_NS     100
`define SW_RESET_CYCLES ((`SW_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== core/phy_mode_pkg.sv ====
// Types shared by the mode and control block
package phy_mode_pkg;

  typedef struct packed {
    logic speed;
    logic autoneg;
    logic isolate;
    logic duplex;
    logic fef_enable;
    logic back_to_back;
  } strap_type;

  typedef struct packed {
    logic power_down;
    logic power_saving;
    logic fibre_mode;
    logic autoneg_active;
    logic mdix_enable;
    logic speed_100;
    logic full_duplex;
    logic loopback;
    logic isolate;
    logic collision_test;
    logic block_10base_link;
    logic link_up;
  } mode_type;

  typedef enum logic [1:0] {
    copper_mode,
    fibre_no_signal,
    fibre_signal
  } fibre_state_type;

  typedef enum logic {
    reset_hold,
    running
  } reset_state_type;

endpackage : phy_mode_pkg

// ==== core/bit_sync.sv ====
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : bit_sync

`default_nettype wire

// ==== core/fef_pattern.sv ====
// Far-end-fault pattern generator and receive detector
`timescale 1ns/1ps
`default_nettype none
`include "phy_mode_defines.svh"

module fef_pattern #(
  parameter int ONES = `FEF_ONES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic bit_en,
  input  wire logic gen_en,
  input  wire logic data_bit,
  input  wire logic rx_bit,
  output logic      tx_bit,
  output logic      fef_seen
);

  logic [6:0] gen_count;
  logic [6:0] run_count;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit: ones then one zero, else MAC data untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_count <= 7'h00;
      tx_bit    <= 1'b0;
    end else if (!gen_en) begin
      gen_count <= 7'h00;
      tx_bit    <= data_bit;
    end else if (bit_en) begin
      tx_bit    <= (gen_count != 7'(ONES));
      gen_count <= (gen_count == 7'(ONES)) ? 7'h00 : gen_count + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive: exactly ONES ones closed by a zero marks a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_count <= 7'h00;
      fef_seen  <= 1'b0;
    end else if (bit_en) begin
      if (rx_bit) begin
        // Saturate just past ONES so long idle runs do not match
        if (run_count <= 7'(ONES)) begin
          run_count <= run_count + 7'h01;
        end
      end else begin
        fef_seen  <= (run_count == 7'(ONES));
        run_count <= 7'h00;
      end
    end
  end

endmodule : fef_pattern

`default_nettype wire

// ==== core/phy_mode_control_registers.sv ====
// Mode, power and control registers of the 10/100 transceiver
//
// Summary of operation
// R01: Power down by control bit or pin
// R02: Power saving idles all but energy detect
// R03: Fibre mode forces 100M, no autoneg, no auto crossover
// R04: Fibre select decodes copper, no-signal, signal
// R05: No signal sends 84 ones then zero
// R06: Received fault pattern forces link down
// R07: Received fault leaves transmit data alone
// R08: Low strap suppresses fault pattern generation
// R09: System wires two devices back to back
// R10: Back-to-back copper autoneg blocks 10M link
// R11: Media converter: TXD2 tristates, RXD2 energy
// R12: Registers 0-8, 15h, 1bh, 1fh exist
// R13: Control bit 15 resets, self-clears
// R14: Control bit 14 loop-back, resets zero
// R15: Control bit 13 speed, strap default
// R16: Control bit 12 autoneg overrides speed, duplex
// R17: Control bit 10 isolates MAC and line
// R18: Control bit 9 restarts autoneg, self-clears
// R19: Control bit 8 duplex, strap default
// R20: Control bit 7 collision test, resets zero
// R21: Control bit 0 disables transmitter
// R22: Status 15:11 report fixed abilities
// R23: Control bits 6:1 read zero
`timescale 1ns/1ps
`default_nettype none
`include "phy_mode_defines.svh"

module phy_mode_control_registers
  import phy_mode_pkg::*;
#(
  parameter logic [15:0] ID_HIGH = 16'h1234,  // Arbitrary identity value
  parameter logic [15:0] ID_LOW  = 16'h5678   // Arbitrary identity value
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire strap_type   strap_pins,
  input  wire logic        power_down_pin_n,
  input  wire logic        fibre_above_low,
  input  wire logic        fibre_above_high,
  input  wire logic        txd2_pin,
  input  wire logic        energy_detect_pin,
  input  wire logic        link_ok,
  input  wire logic        an_speed_100,
  input  wire logic        an_full_duplex,
  input  wire logic        rx_error_pulse,
  input  wire logic        line_bit_en,
  input  wire logic        mac_tx_bit,
  input  wire logic        rx_line_bit,
  output mode_type         mode,
  output logic             line_tx_bit,
  output logic             line_tx_enable,
  output logic             rxd2_energy,
  output logic             an_restart,
  output logic             soft_reset_active
);

  localparam int RST_CYCLES = `SW_RESET_CYCLES;

  strap_type        strap_sync;
  logic             pd_pin_n_sync;
  logic             fx_low_sync;
  logic             fx_high_sync;
  logic             txd2_sync;
  logic             energy_sync;
  strap_type        strap;
  reset_state_type  reset_state;
  logic [7:0]       reset_count;
  logic [15:0]      control;
  logic [15:0]      vendor;
  logic [15:0]      rx_err_count;
  fibre_state_type  fibre_state;
  logic             fef_rx_seen;
  logic             fef_tx_bit;
  logic             fef_gen;
  logic [4:0]       reg_index;
  logic             mapped;
  logic             wr_access;
  logic [15:0]      read_value;
  logic             next_power_down;
  logic             next_fibre;
  logic             next_an_active;
  logic             next_link_up;
  logic             next_block_10;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  bit_sync #(
    .WIDTH ($bits(strap_type) + 5)
  ) pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({strap_pins, power_down_pin_n, fibre_above_low,
                fibre_above_high, txd2_pin, energy_detect_pin}),
    .sync_out ({strap_sync, pd_pin_n_sync, fx_low_sync,
                fx_high_sync, txd2_sync, energy_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencing; straps are caught at the end of every reset hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_state <= reset_hold;
      reset_count <= 8'h00;
    end else begin
      unique case (reset_state)
        reset_hold: begin
          // Hold long enough for the strap synchroniser to settle
          if (reset_count >= 8'(RST_CYCLES - 1)) begin
            reset_state <= running;
            reset_count <= 8'h00;
          end else begin
            reset_count <= reset_count + 8'h01;
          end
        end
        running: begin
          if (wr_access && reg_index == `IDX_CONTROL && pwdata[`CTL_RESET]) begin
            reset_state <= reset_hold;  // [R13]
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap <= '0;
    end else if (reset_state == reset_hold) begin
      strap <= strap_sync;
    end
  end

  assign soft_reset_active = (reset_state == reset_hold);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign reg_index = paddr[6:2];
  assign wr_access = psel && penable && pwrite && mapped;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !mapped;

  always_comb begin
    unique case (reg_index)
      `IDX_CONTROL, `IDX_STATUS, `IDX_ID_HIGH, `IDX_ID_LOW,
      `IDX_AN_ADVERT, `IDX_AN_PARTNER, `IDX_AN_EXPANSION,
      `IDX_AN_NEXT_PAGE, `IDX_PARTNER_NP, `IDX_RX_ERR_COUNT,
      `IDX_IRQ_CTRL, `IDX_MODE_STATUS, `IDX_VENDOR_CTRL:
        mapped = !paddr[7];  // [R12]
      default:
        mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Basic control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= 16'h0000;
    end else if (reset_state == reset_hold) begin
      control                 <= 16'h0000;  // [R14] [R20] [R21]
      control[`CTL_SPEED]     <= strap_sync.speed;  // [R15]
      control[`CTL_AN_ENABLE] <= strap_sync.autoneg;  // [R16]
      control[`CTL_ISOLATE]   <= strap_sync.isolate;  // [R17]
      control[`CTL_DUPLEX]    <= strap_sync.duplex;  // [R19]
    end else if (wr_access && reg_index == `IDX_CONTROL) begin
      // Self-clearing and reserved bits are never stored
      control <= pwdata[15:0] & `CTL_RW_MASK;  // [R23]
    end
  end

  // Restart pulse lasts one cycle and is the bit's only trace
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      an_restart <= 1'b0;
    end else begin
      an_restart <= wr_access && reg_index == `IDX_CONTROL &&
                    pwdata[`CTL_AN_RESTART] && !pwdata[`CTL_RESET] &&
                    reset_state == running;  // [R18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vendor control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vendor <= `VND_RESET;
    end else if (reset_state == reset_hold) begin
      vendor <= `VND_RESET;
    end else if (wr_access && reg_index == `IDX_VENDOR_CTRL) begin
      vendor <= pwdata[15:0] & `VND_RW_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive error counter, saturating, read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_err_count <= 16'h0000;
    end else if (reset_state == reset_hold) begin
      rx_err_count <= 16'h0000;
    end else if (rx_error_pulse && rx_err_count != 16'hffff) begin
      rx_err_count <= rx_err_count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fibre select decode
  always_comb begin
    if (!fx_low_sync) begin
      fibre_state = copper_mode;  // [R04]
    end else if (!fx_high_sync) begin
      fibre_state = fibre_no_signal;
    end else begin
      fibre_state = fibre_signal;
    end
  end

  assign fef_gen = (fibre_state == fibre_no_signal) && strap.fef_enable;  // [R05] [R08]

  fef_pattern #(
    .ONES (`FEF_ONES)
  ) fef (
    .pclk     (pclk),
    .presetn  (presetn),
    .bit_en   (line_bit_en),
    .gen_en   (fef_gen),
    .data_bit (mac_tx_bit),
    .rx_bit   (rx_line_bit),
    .tx_bit   (fef_tx_bit),
    .fef_seen (fef_rx_seen)
  );

  // Transmit path ignores received faults entirely
  assign line_tx_bit = fef_tx_bit;  // [R07]

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode
  assign next_power_down = control[`CTL_POWER_DOWN] || !pd_pin_n_sync;  // [R01]
  assign next_fibre      = (fibre_state != copper_mode);  // [R03]
  assign next_an_active  = control[`CTL_AN_ENABLE] && !next_fibre;
  // Converter copper side: autoneg must not settle on 10M
  assign next_block_10   = strap.back_to_back && !next_fibre &&
                           next_an_active;  // [R10]
  assign next_link_up    = link_ok && !fef_rx_seen && !next_power_down &&
                           (fibre_state != fibre_no_signal) &&
                           !(next_block_10 && !an_speed_100);  // [R06]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= '0;
    end else begin
      mode.power_down     <= next_power_down;
      // Saving mode needs no link and no line energy
      mode.power_saving   <= !vendor[`VND_PS_DISABLE] && !next_link_up &&
                             !energy_sync;  // [R02]
      mode.fibre_mode     <= next_fibre;
      mode.autoneg_active <= next_an_active;  // [R03]
      mode.mdix_enable    <= !vendor[`VND_MDIX_DISABLE] && !next_fibre;
      if (next_fibre) begin
        mode.speed_100 <= 1'b1;  // [R03]
      end else if (next_an_active) begin
        mode.speed_100 <= an_speed_100;  // [R16]
      end else begin
        mode.speed_100 <= control[`CTL_SPEED];  // [R15]
      end
      mode.full_duplex       <= next_an_active ? an_full_duplex
                                               : control[`CTL_DUPLEX];  // [R16] [R19]
      mode.loopback          <= control[`CTL_LOOPBACK];  // [R14]
      mode.isolate           <= control[`CTL_ISOLATE];  // [R17]
      mode.collision_test    <= control[`CTL_COL_TEST];  // [R20]
      mode.block_10base_link <= next_block_10;
      mode.link_up           <= next_link_up;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line driver and converter energy output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_tx_enable <= 1'b0;
      rxd2_energy    <= 1'b0;
    end else begin
      line_tx_enable <= !(next_power_down || control[`CTL_ISOLATE] ||
                          control[`CTL_TX_DISABLE] || mode.power_saving ||
                          (strap.back_to_back && txd2_sync) ||
                          reset_state == reset_hold);  // [R11] [R17] [R21]
      rxd2_energy    <= strap.back_to_back && energy_sync;  // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    read_value = 16'h0000;
    unique case (reg_index)
      `IDX_CONTROL: begin
        read_value                  = control;
        read_value[`CTL_RESET]      = (reset_state == reset_hold);  // [R13]
        read_value[`CTL_AN_RESTART] = an_restart;  // [R18]
      end
      `IDX_STATUS: begin
        read_value[15:`STS_ABILITY_LSB] = `STS_ABILITY;  // [R22]
        read_value[`STS_LINK]           = mode.link_up;
      end
      `IDX_ID_HIGH:      read_value = ID_HIGH;
      `IDX_ID_LOW:       read_value = ID_LOW;
      `IDX_RX_ERR_COUNT: read_value = rx_err_count;
      `IDX_VENDOR_CTRL:  read_value = vendor;
      `IDX_MODE_STATUS: begin
        read_value[0] = mode.fibre_mode;
        read_value[1] = (fibre_state == fibre_signal);
        read_value[2] = fef_gen;
        read_value[3] = fef_rx_seen;
        read_value[4] = mode.power_down;
        read_value[5] = mode.power_saving;
        read_value[6] = strap.back_to_back;
      end
      default:           read_value = 16'h0000;
    endcase
  end

  // Read data is latched in the setup phase, so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= (!pwrite && mapped) ? {16'h0000, read_value} : 32'h0000_0000;
    end
  end

endmodule : phy_mode_control_registers

`default_nettype wire

// ==== verif/phy_mode_props.sv ====
// Port-level checks of the mode and control block
`timescale 1ns/1ps
`default_nettype none
`include "phy_mode_defines.svh"

module phy_mode_props
  import phy_mode_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire strap_type   strap_pins,
  input wire logic        power_down_pin_n,
  input wire logic        txd2_pin,
  input wire logic        energy_detect_pin,
  input wire mode_type    mode,
  input wire logic        line_tx_enable,
  input wire logic        rxd2_energy,
  input wire logic        an_restart,
  input wire logic        soft_reset_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic ctl_wr;
  logic conv;
  logic acc;
  assign ctl_wr = psel && penable && pwrite && paddr[7:2] == {1'b0, `IDX_CONTROL};
  // Hold excluded: converter pins are only meaningful once straps are caught
  assign conv   = strap_pins.back_to_back && !soft_reset_active;
  assign acc    = psel && penable;

  ////////////////////////////////////////
  a_restart_pulse: assert property (ctl_wr && pwdata[9] && !pwdata[15] && !soft_reset_active
    |=> an_restart) else $error("restart pulse missing");
  a_restart_once: assert property (an_restart |=> !an_restart)
    else $error("restart pulse too long");
  a_soft_reset: assert property (ctl_wr && pwdata[15] && !soft_reset_active
    |=> soft_reset_active) else $error("soft reset not entered");
  a_reset_hold: assert property ($rose(soft_reset_active)
    |-> soft_reset_active[*8] ##[1:4] !soft_reset_active) else $error("reset hold length");
  a_bad_index: assert property (acc && (paddr[7] || paddr[6:2] == 5'h10)
    |-> pslverr && prdata == 32'h0) else $error("unmapped index accepted");
  a_good_index: assert property (acc && !paddr[7]
    && (paddr[6:2] <= 5'h08 || paddr[6:2] inside {5'h15, 5'h1b, 5'h1f})
    |-> !pslverr) else $error("mapped index refused");
  a_fibre_forces: assert property (mode.fibre_mode
    |-> mode.speed_100 && !mode.autoneg_active && !mode.mdix_enable)
    else $error("fibre mode settings");
  a_pin_power: assert property ((!power_down_pin_n && !soft_reset_active)[*4]
    |-> mode.power_down) else $error("power-down pin ignored");
  a_isolate_quiet: assert property (mode.isolate && $past(mode.isolate)
    |-> !line_tx_enable) else $error("isolated but driving");
  a_saving_quiet: assert property (mode.power_saving && $past(mode.power_saving)
    |-> !line_tx_enable) else $error("saving but driving");
  a_conv_tristate: assert property ((conv && txd2_pin)[*4] |-> !line_tx_enable)
    else $error("converter tristate ignored");
  a_conv_energy: assert property ((conv && energy_detect_pin)[*4] |-> rxd2_energy)
    else $error("energy not reported");
  a_block_link: assert property (mode.block_10base_link && !mode.speed_100 |-> !mode.link_up)
    else $error("blocked link shown up");
endmodule : phy_mode_props

`default_nettype wire

// ==== verif/line_partner.sv ====
// Line-side model: bit timing and received pattern
`timescale 1ns/1ps
`default_nettype none

module line_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic send_fef,
  output logic      line_bit_en,
  output logic      rx_line_bit
);
  logic [1:0] phase;
  logic [6:0] run;

  // One bit every four clocks; idle data toggles so no fault run forms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase       <= 2'h0;
      run         <= 7'h0;
      line_bit_en <= 1'b0;
      rx_line_bit <= 1'b0;
    end else begin
      phase       <= phase + 2'h1;
      line_bit_en <= (phase == 2'h3);
      if (phase == 2'h3) begin
        run         <= (run == 7'h54) ? 7'h0 : run + 7'h1;
        rx_line_bit <= send_fef ? (run != 7'h54) : ~rx_line_bit;
      end
    end
  end
endmodule : line_partner

`default_nettype wire

// ==== verif/testbench.sv ====
// Directed bench of the mode and control registers
`timescale 1ns/1ps
`default_nettype none
`include "phy_mode_defines.svh"

module testbench
  import phy_mode_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  strap_type   strap_pins = 6'h27; // Back-to-back strap high
  logic        power_down_pin_n = 1'b1;
  logic        fibre_above_low = 1'b0;
  logic        fibre_above_high = 1'b0;
  logic        txd2_pin = 1'b0;
  logic        energy_detect_pin = 1'b0;
  logic        link_ok = 1'b0;
  logic        an_speed_100 = 1'b1;
  logic        an_full_duplex = 1'b0;
  logic        rx_error_pulse = 1'b0;
  logic        mac_tx_bit = 1'b0;
  logic        send_fef = 1'b0;
  logic        line_bit_en;
  logic        rx_line_bit;
  mode_type    mode;
  logic        line_tx_bit;
  logic        line_tx_enable;
  logic        rxd2_energy;
  logic        an_restart;
  logic        soft_reset_active;
  logic [31:0] rdata;
  logic        rerr;
  int          n_errors = 0;
  int          check_count = 0;
  int          g;
  logic [4:0]  map [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
                            5'h08, 5'h15, 5'h1b, 5'h1f};

  always #5 pclk = ~pclk;

  phy_mode_control_registers dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .strap_pins, .power_down_pin_n, .fibre_above_low, .fibre_above_high,
    .txd2_pin, .energy_detect_pin, .link_ok, .an_speed_100, .an_full_duplex,
    .rx_error_pulse, .line_bit_en, .mac_tx_bit, .rx_line_bit, .mode, .line_tx_bit,
    .line_tx_enable, .rxd2_energy, .an_restart, .soft_reset_active
  );

  line_partner partner (.pclk, .presetn, .send_fef, .line_bit_en, .rx_line_bit);

  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // Arguments hold values from before the calling edge; report at the falling edge
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    @(negedge pclk);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chb

  task automatic apb(input logic [4:0] i, input logic w, input logic [15:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= {1'b0, i, 2'b00};
    pwrite  <= w;
    pwdata  <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a slave that never answers
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    apb(i, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [4:0] i, input logic [15:0] e);
    apb(i, 1'b0, 16'h0);
    chk(rdata, {16'h0, e});
  endtask : rd

  task automatic wait_idle();
    for (int i = 0; i < 40 && soft_reset_active !== 1'b0; i++) @(posedge pclk);
    chb(soft_reset_active, 1'b0);
  endtask : wait_idle

  // Distance in line bits between the first two transmitted zeros, 0 if fewer
  task automatic gap(output int d);
    int last;
    last = -1;
    d = 0;
    for (int i = 0; i < 200; i++) begin
      do @(posedge pclk); while (line_bit_en !== 1'b1);
      @(posedge pclk);
      if (line_tx_bit === 1'b0) begin
        if (last >= 0 && d == 0) d = i - last;
        last = i;
      end
    end
  endtask : gap

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  ////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    rd(`IDX_CONTROL, 16'h2100);
    rd(`IDX_STATUS, 16'h7800);
    wr(`IDX_STATUS, 16'hffff);
    rd(`IDX_STATUS, 16'h7800);
    cyc(1);
    rx_error_pulse <= 1'b1;
    cyc(1);
    rx_error_pulse <= 1'b0;
    rd(`IDX_RX_ERR_COUNT, 16'h0001);
    foreach (map[k]) begin
      apb(map[k], 1'b0, 16'h0);
      chb(rerr, 1'b0);
    end
    apb(5'h10, 1'b0, 16'h0);
    chb(rerr, 1'b1);
    $display("test registers done");
    chb(mode.power_saving, 1'b1);
    wr(`IDX_VENDOR_CTRL, 16'h0400);
    rd(`IDX_VENDOR_CTRL, 16'h0400);
    chb(mode.power_saving, 1'b0);
    wr(`IDX_VENDOR_CTRL, 16'h0000);
    link_ok <= 1'b1;
    cyc(4);
    chb(line_tx_enable, 1'b1);
    cyc(1);
    txd2_pin <= 1'b1;
    energy_detect_pin <= 1'b1;
    cyc(5);
    chb(line_tx_enable, 1'b0);
    chb(rxd2_energy, 1'b1);
    cyc(1);
    txd2_pin <= 1'b0;
    $display("test power and converter done");
    wr(`IDX_CONTROL, 16'h41ff);
    rd(`IDX_CONTROL, 16'h4181);
    chb(mode.loopback, 1'b1);
    chb(mode.collision_test, 1'b1);
    chb(mode.speed_100, 1'b0);
    chb(mode.full_duplex, 1'b1);
    chb(line_tx_enable, 1'b0);
    wr(`IDX_CONTROL, 16'h0400);
    cyc(2);
    chb(mode.isolate, 1'b1);
    wr(`IDX_CONTROL, 16'h1300);
    cyc(1);
    rd(`IDX_CONTROL, 16'h1100);
    chb(mode.speed_100, 1'b1);
    chb(mode.full_duplex, 1'b0);
    cyc(1);
    an_speed_100 <= 1'b0;
    cyc(2);
    an_speed_100 <= 1'b1;
    chb(mode.link_up, 1'b0);
    wr(`IDX_CONTROL, 16'h0800);
    cyc(2);
    chb(mode.power_down, 1'b1);
    wr(`IDX_CONTROL, 16'h0000);
    cyc(2);
    chb(mode.power_down, 1'b0);
    cyc(1);
    power_down_pin_n <= 1'b0;
    cyc(5);
    chb(mode.power_down, 1'b1);
    cyc(1);
    power_down_pin_n <= 1'b1;
    wr(`IDX_CONTROL, 16'h8000);
    cyc(1);
    rd(`IDX_CONTROL, 16'ha100);
    chb(soft_reset_active, 1'b1);
    wait_idle();
    rd(`IDX_CONTROL, 16'h2100);
    $display("test control bits done");
    wr(`IDX_CONTROL, 16'h1000);
    mac_tx_bit <= 1'b1;
    fibre_above_low <= 1'b1;
    cyc(6);
    chb(mode.fibre_mode, 1'b1);
    chb(mode.autoneg_active, 1'b0);
    gap(g);
    chk(g, 32'h55);
    strap_pins.fef_enable <= 1'b0;
    wr(`IDX_CONTROL, 16'h8000);
    wait_idle();
    gap(g);
    chk(g, 32'h0);
    cyc(1);
    fibre_above_high <= 1'b1;
    cyc(6);
    chb(mode.link_up, 1'b1);
    cyc(1);
    send_fef <= 1'b1;
    for (int i = 0; i < 1000 && mode.link_up !== 1'b0; i++) @(posedge pclk);
    chb(mode.link_up, 1'b0);
    rd(`IDX_STATUS, 16'h7800);
    cyc(1);
    mac_tx_bit <= 1'b0;
    cyc(3);
    chb(line_tx_bit, 1'b0);
    $display("test fibre done");
    conclude();
  end
endmodule : testbench

bind phy_mode_control_registers phy_mode_props props (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pslverr,
  .strap_pins, .power_down_pin_n, .txd2_pin, .energy_detect_pin, .mode,
  .line_tx_enable, .rxd2_energy, .an_restart, .soft_reset_active
);

`default_nettype wire
